// file: dpd_map.svh
// offsets, field positions, reset values and timing counts of the diag register set
// assumes inclusion by bare name from the design file and the test bench
`ifndef DPD_MAP_SVH
`define DPD_MAP_SVH
`define DPD_REC_PARAM 8'h00
`define DPD_REC_SHORT 8'h00
`define DPD_REC_FULL 8'h01
`define DPD_REC_FILT0 8'h80
`define DPD_REC_FILT3 8'h83
`define DPD_BYTE_DIAG_IRQ_ENABLE 5'h00
`define DPD_BYTE_WB_EN 5'h01
`define DPD_SHORT_LEN 5'h04
`define DPD_FULL_LEN 5'h14
`define DPD_B_ERR_A 5'h00
`define DPD_B_MODCLASS 5'h01
`define DPD_B_RSVD 5'h02
`define DPD_B_ERR_D 5'h03
`define DPD_B_CHKIND 5'h04
`define DPD_B_BITS 5'h05
`define DPD_B_NCH 5'h06
`define DPD_B_CHMAP 5'h07
`define DPD_B_CH0 5'h08
`define DPD_B_TS0 5'h10
`define DPD_IRQ_ON 8'h40
`define DPD_IRQ_OFF 8'h00
`define DPD_RST_DIAG_IRQ_ENABLE 8'h00
`define DPD_RST_WB_EN 8'h00
`define DPD_RST_FILT 8'h11
`define DPD_MODCLASS 8'h1f
`define DPD_CHKIND 8'h70
`define DPD_BITS_PER_CH 8'h08
`define DPD_NUM_CH 8'h08
`define DPD_EA_MOD_FAIL 0
`define DPD_EA_INTERNAL 1
`define DPD_EA_EXTERNAL 2
`define DPD_EA_CHANNEL 3
`define DPD_EA_AUX 4
`define DPD_EA_PARAM 7
`define DPD_ED_OVF 3
`define DPD_ED_COMM 4
`define DPD_CE_PARAM 0
`define DPD_CE_WB 4
`define DPD_CLK_MHZ 200
`define DPD_TICK_US 1
`define DPD_US_TICK_CYC (`DPD_CLK_MHZ * `DPD_TICK_US)
`define DPD_FT1_US 100
`define DPD_FT2_US 400
`define DPD_FT3_US 800
`define DPD_FT4_US 1600
`define DPD_FT5_US 3200
`define DPD_FT6_US 10000
`define DPD_FT7_US 20000
`endif

// file: dpd_pkg.sv
// types shared by the diag register set
// assumes dpd_map.svh sits in the include path
package dpd_pkg;
    timeunit 1ns;
    timeprecision 100ps;
    typedef logic [7:0] dpd_byte_t;
    typedef logic [14:0] dpd_us_t;
    typedef logic [3:0] dpd_code_t;
endpackage

// file: dpd_regs.sv
// parameter and diagnostic record set of an eight channel digital input module
// assumes record access strobes come from backplane logic on sys_clk; status pins are asynchronous
`include "dpd_map.svh"
module dpd_regs #(
    parameter int NUM_CH = 8,
    parameter int US_TICK_CYC = `DPD_US_TICK_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [NUM_CH-1:0] input_channel,
    input wire logic [NUM_CH-1:0] wire_break_raw,
    input wire logic module_fail_in,
    input wire logic aux_supply_missing_in,
    input wire logic comm_error_in,
    input wire logic diag_overflow_in,
    input wire logic sys_stop,
    input wire logic wr_req,
    input wire logic [7:0] wr_record,
    input wire logic [4:0] wr_byte,
    input wire logic [7:0] wr_data,
    input wire logic rd_req,
    input wire logic [7:0] rd_record,
    input wire logic [4:0] rd_byte,
    output logic wr_ack_q,
    output logic wr_err_q,
    output logic rd_valid_q,
    output logic rd_err_q,
    output logic [7:0] rd_data_q,
    output logic [NUM_CH-1:0] filtered_inputs,
    output logic diag_irq_q
);
    timeunit 1ns;
    timeprecision 100ps;

    // byte packing assumes eight channels; the divider is 16 bits wide
    if (NUM_CH != 8 || US_TICK_CYC < 1 || US_TICK_CYC > 65535) begin : g_bad_param
        $error("dpd_regs: NUM_CH must be 8 and US_TICK_CYC 1..65535");
    end

    localparam int NP = NUM_CH / 2;
    localparam logic [15:0] TICK_LAST = 16'(US_TICK_CYC - 1);

    // pin synchronisers
    logic [NUM_CH-1:0] din_s1_q, din_q, wb_s1_q, wb_q;
    logic [3:0] st_s1_q, st_q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            din_s1_q <= '0;
            din_q <= '0;
            wb_s1_q <= '0;
            wb_q <= '0;
            st_s1_q <= 4'h0;
            st_q <= 4'h0;
        end else begin
            din_s1_q <= input_channel;
            din_q <= din_s1_q;
            wb_s1_q <= wire_break_raw;
            wb_q <= wb_s1_q;
            st_s1_q <= {diag_overflow_in, comm_error_in, aux_supply_missing_in, module_fail_in};
            st_q <= st_s1_q;
        end
    end

    // one microsecond enable and the free running ticker
    logic [15:0] div_q;
    logic us_tick_q;
    logic [31:0] us_cnt_q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            div_q <= 16'h0000;
            us_tick_q <= 1'b0;
        end else if (div_q == TICK_LAST) begin
            div_q <= 16'h0000;
            us_tick_q <= 1'b1;
        end else begin
            div_q <= div_q + 16'h0001;
            us_tick_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            us_cnt_q <= 32'h0000_0000;
        end else if (us_tick_q) begin
            us_cnt_q <= us_cnt_q + 32'h0000_0001;
        end
    end

    // parameter bytes
    logic [7:0] diag_irq_enable_q, wire_break_enable_q;
    logic [8*NP-1:0] filter_time_pair_q;
    logic wr_par, wr_filt, wr_ok;
    assign wr_par = wr_record == `DPD_REC_PARAM
        && (wr_byte == `DPD_BYTE_DIAG_IRQ_ENABLE || wr_byte == `DPD_BYTE_WB_EN);
    assign wr_filt = wr_record >= `DPD_REC_FILT0 && wr_record <= `DPD_REC_FILT3 && wr_byte == 5'h00;
    assign wr_ok = (wr_par && sys_stop) || wr_filt;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            diag_irq_enable_q <= `DPD_RST_DIAG_IRQ_ENABLE;
            wire_break_enable_q <= `DPD_RST_WB_EN;
            filter_time_pair_q <= {NP{`DPD_RST_FILT}};
        end else if (wr_req && wr_ok) begin
            if (wr_filt) begin
                filter_time_pair_q[8*wr_record[1:0] +: 8] <= wr_data;
            end else if (wr_byte == `DPD_BYTE_DIAG_IRQ_ENABLE) begin
                diag_irq_enable_q <= wr_data;
            end else begin
                wire_break_enable_q <= wr_data;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_ack_q <= 1'b0;
            wr_err_q <= 1'b0;
        end else begin
            wr_ack_q <= wr_req && wr_ok;
            wr_err_q <= wr_req && !wr_ok;
        end
    end

    // code to filter time, zero marks an illegal code
    function automatic dpd_pkg::dpd_us_t ft_us(input dpd_pkg::dpd_code_t c);
        case (c)
            4'h1: ft_us = 15'(`DPD_FT1_US);
            4'h2: ft_us = 15'(`DPD_FT2_US);
            4'h3: ft_us = 15'(`DPD_FT3_US);
            4'h4: ft_us = 15'(`DPD_FT4_US);
            4'h5: ft_us = 15'(`DPD_FT5_US);
            4'h6: ft_us = 15'(`DPD_FT6_US);
            4'h7: ft_us = 15'(`DPD_FT7_US);
            default: ft_us = 15'h0000;
        endcase
    endfunction

    logic [8*NUM_CH-1:0] ch_err_d;
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            dpd_pkg::dpd_code_t code;
            dpd_pkg::dpd_us_t lim;
            dpd_pkg::dpd_us_t cnt_q;
            logic filt_q;
            assign code = filter_time_pair_q[8*(g/2) + 4*(g%2) +: 4];
            assign lim = ft_us(code);
            // input held until stable for the filter time
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    cnt_q <= 15'h0000;
                    filt_q <= 1'b0;
                end else if (din_q[g] == filt_q || lim == 15'h0000) begin
                    cnt_q <= 15'h0000;
                end else if (us_tick_q) begin
                    if (cnt_q + 15'h0001 >= lim) begin
                        cnt_q <= 15'h0000;
                        filt_q <= din_q[g];
                    end else begin
                        cnt_q <= cnt_q + 15'h0001;
                    end
                end
            end
            assign filtered_inputs[g] = filt_q;
            logic [7:0] err_b;
            always_comb begin
                err_b = 8'h00;
                err_b[`DPD_CE_PARAM] = lim == 15'h0000;
                err_b[`DPD_CE_WB] = wb_q[g] && wire_break_enable_q[g];
            end
            assign ch_err_d[8*g +: 8] = err_b;
        end
    endgenerate

    // error bytes
    logic [8*NUM_CH-1:0] ch_err_q;
    logic [7:0] ch_map_q, err_a_q, err_d_q, ch_map_d, err_a_d, err_d_d;
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            ch_map_d[i] = |ch_err_d[8*i +: 8];
        end
        err_d_d = 8'h00;
        err_d_d[`DPD_ED_OVF] = st_q[3];
        err_d_d[`DPD_ED_COMM] = st_q[2];
        err_a_d = 8'h00;
        err_a_d[`DPD_EA_MOD_FAIL] = st_q[0];
        err_a_d[`DPD_EA_INTERNAL] = st_q[2] || st_q[3];
        err_a_d[`DPD_EA_EXTERNAL] = st_q[1] || (|(wb_q & wire_break_enable_q));
        err_a_d[`DPD_EA_CHANNEL] = |ch_map_d;
        err_a_d[`DPD_EA_AUX] = st_q[1];
        err_a_d[`DPD_EA_PARAM] = |(ch_err_d & {NUM_CH{8'h01}});
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ch_err_q <= '0;
            ch_map_q <= 8'h00;
            err_a_q <= 8'h00;
            err_d_q <= 8'h00;
        end else begin
            ch_err_q <= ch_err_d;
            ch_map_q <= ch_map_d;
            err_a_q <= err_a_d;
            err_d_q <= err_d_d;
        end
    end

    // a new condition is any error bit rising, whether or not the interrupt is on
    logic new_evt;
    assign new_evt = |({ch_err_d, err_a_d, err_d_d} & ~{ch_err_q, err_a_q, err_d_q});

    logic [31:0] diag_timestamp_us_q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            diag_timestamp_us_q <= 32'h0000_0000;
        end else if (new_evt) begin
            diag_timestamp_us_q <= us_cnt_q;
        end
    end

    // interrupt only with exact enable code
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            diag_irq_q <= 1'b0;
        end else begin
            diag_irq_q <= new_evt && diag_irq_enable_q == `DPD_IRQ_ON;
        end
    end

    // read mux
    logic [7:0] rd_mux;
    logic rd_hit;
    logic [4:0] rel;
    always_comb begin
        rd_mux = 8'h00;
        rd_hit = 1'b0;
        rel = rd_byte - `DPD_B_CH0;
        if (rd_record >= `DPD_REC_FILT0 && rd_record <= `DPD_REC_FILT3) begin
            rd_hit = rd_byte == 5'h00;
            if (rd_hit) begin
                rd_mux = filter_time_pair_q[8*rd_record[1:0] +: 8];
            end
        end else if ((rd_record == `DPD_REC_SHORT && rd_byte < `DPD_SHORT_LEN)
                || (rd_record == `DPD_REC_FULL && rd_byte < `DPD_FULL_LEN)) begin
            rd_hit = 1'b1;
            if (rd_byte >= `DPD_B_TS0) begin
                rd_mux = diag_timestamp_us_q[8*rd_byte[1:0] +: 8];
            end else if (rd_byte >= `DPD_B_CH0) begin
                rd_mux = ch_err_q[8*rel[2:0] +: 8];
            end else begin
                case (rd_byte)
                    `DPD_B_ERR_A: rd_mux = err_a_q;
                    `DPD_B_MODCLASS: rd_mux = `DPD_MODCLASS;
                    `DPD_B_RSVD: rd_mux = 8'h00;
                    `DPD_B_ERR_D: rd_mux = err_d_q;
                    `DPD_B_CHKIND: rd_mux = `DPD_CHKIND;
                    `DPD_B_BITS: rd_mux = `DPD_BITS_PER_CH;
                    `DPD_B_NCH: rd_mux = `DPD_NUM_CH;
                    default: rd_mux = ch_map_q;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_valid_q <= 1'b0;
            rd_err_q <= 1'b0;
            rd_data_q <= 8'h00;
        end else begin
            rd_valid_q <= rd_req;
            rd_err_q <= rd_req && !rd_hit;
            if (rd_req) begin
                rd_data_q <= rd_mux;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_irq_gate_on: assert property (diag_irq_q |-> $past(diag_irq_enable_q) == 8'h40)
        else $error("irq raised while enable byte not 40h");
    a_irq_on_event: assert property ((new_evt && diag_irq_enable_q == 8'h40) |=> diag_irq_q)
        else $error("new error with irq enabled gave no irq");
    a_wb_gate: assert property ((({ch_err_q[60], ch_err_q[52], ch_err_q[44], ch_err_q[36], ch_err_q[28],
        ch_err_q[20], ch_err_q[12], ch_err_q[4]}) & ~$past(wire_break_enable_q)) == 8'h00)
        else $error("wire break reported on disabled channel");
    a_stop_guard: assert property ((wr_req && wr_record == 8'h00 && !sys_stop) |=> wr_err_q
        && $stable(diag_irq_enable_q) && $stable(wire_break_enable_q))
        else $error("enable record written outside stop");
    a_filt_write: assert property ((wr_req && wr_record == 8'h81 && wr_byte == 5'h00)
        |=> wr_ack_q && filter_time_pair_q[15:8] == $past(wr_data))
        else $error("filter record 81h not stored");
    a_modclass_read: assert property ((rd_req && rd_record == 8'h01 && rd_byte == 5'h01)
        |=> rd_valid_q && !rd_err_q && rd_data_q == 8'h1f)
        else $error("module class not 1Fh");
    a_chkind_read: assert property ((rd_req && rd_record == 8'h01 && rd_byte == 5'h04)
        |=> rd_data_q == 8'h70)
        else $error("channel kind not 70h");
    a_count_read: assert property ((rd_req && rd_record == 8'h01 && (rd_byte == 5'h05 || rd_byte == 5'h06))
        |=> rd_data_q == 8'h08)
        else $error("count byte not 08h");
    a_short_len: assert property ((rd_req && rd_record == 8'h00 && rd_byte == 5'h04) |=> rd_err_q)
        else $error("short record longer than four bytes");
    a_chmap_tie: assert property (ch_map_q[3] == (ch_err_q[31:24] != 8'h00))
        else $error("channel map bit disagrees with channel byte");
    a_ts_capture: assert property (new_evt |=> diag_timestamp_us_q == $past(us_cnt_q))
        else $error("timestamp not captured at event");
    a_param_err: assert property ((filter_time_pair_q[31:28] == 4'h0) |=> err_a_q[7] && ch_err_q[56])
        else $error("illegal filter code not flagged");
    a_irq_en_write: assert property ((wr_req && sys_stop && wr_record == 8'h00 && wr_byte == 5'h00)
        |=> wr_ack_q && diag_irq_enable_q == $past(wr_data)) else $error("irq enable byte not stored");
    a_wb_en_write: assert property ((wr_req && sys_stop && wr_record == 8'h00 && wr_byte == 5'h01)
        |=> wr_ack_q && wire_break_enable_q == $past(wr_data)) else $error("wire break enable not stored");
    a_wb_err: assert property ((wb_q[0] && wire_break_enable_q[0]) |=> ch_err_q[4])
        else $error("enabled wire break not reported");
    a_sum_rsvd: assert property (err_a_q[6:5] == 2'b00)
        else $error("reserved summary bits set");
    a_sum_chan: assert property (err_a_q[3] == (ch_map_q != 8'h00))
        else $error("summary channel bit disagrees with map");
    a_int_rsvd: assert property ((err_d_q & 8'he7) == 8'h00)
        else $error("reserved internal bits set");
    a_ch_rsvd: assert property ((ch_err_q & {NUM_CH{8'hee}}) == '0)
        else $error("reserved channel error bits set");
    a_filt_hold: assert property ((din_q[1] == filtered_inputs[1]) |=> $stable(filtered_inputs[1]))
        else $error("filtered input moved without input change");
    a_ts_hold: assert property (!new_evt |=> $stable(diag_timestamp_us_q))
        else $error("timestamp moved without event");
    a_tick_step: assert property (us_tick_q |=> us_cnt_q == $past(us_cnt_q) + 32'h0000_0001)
        else $error("ticker did not step on tick");
    a_tick_idle: assert property (!us_tick_q |=> $stable(us_cnt_q))
        else $error("ticker moved without tick");
    a_filt_read: assert property ((rd_req && rd_record == 8'h80 && rd_byte == 5'h00) |=> rd_valid_q
        && {24'h00_0000, rd_data_q} == ($past(filter_time_pair_q) & 32'h0000_00ff)) else $error("filter 80h misread");
    a_rd_err_zero: assert property (rd_err_q |-> rd_data_q == 8'h00)
        else $error("unmapped read returned data");
    a_wr_refuse: assert property ((wr_req && wr_record == 8'h84) |=> wr_err_q && $stable(filter_time_pair_q))
        else $error("unmapped record write taken");
endmodule // dpd_regs

// file: dpd_coupler.sv
// far-side model: backplane coupler issuing single-byte record reads and writes
// assumes dpd_regs answers every request exactly one sys_clk cycle later
module dpd_coupler (
    input wire logic sys_clk,
    input wire logic wr_ack_q,
    input wire logic wr_err_q,
    input wire logic rd_valid_q,
    input wire logic rd_err_q,
    input wire logic [7:0] rd_data_q,
    output logic sys_stop,
    output logic wr_req,
    output logic [7:0] wr_record,
    output logic [4:0] wr_byte,
    output logic [7:0] wr_data,
    output logic rd_req,
    output logic [7:0] rd_record,
    output logic [4:0] rd_byte
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        {sys_stop, wr_req, rd_req} = 3'b000;
        {wr_record, wr_byte, wr_data} = '0;
        {rd_record, rd_byte} = '0;
    end

    task automatic wr(input logic [7:0] rec, input logic [4:0] idx, input logic [7:0] dat, input logic stop,
                      output logic ack, output logic err);
        @(posedge sys_clk);
        #1;
        sys_stop = stop;
        {wr_record, wr_byte, wr_data} = {rec, idx, dat};
        wr_req = 1'b1;
        @(posedge sys_clk);
        #1;
        wr_req = 1'b0;
        ack = wr_ack_q;
        err = wr_err_q;
        // released lines never keep the last value
        {wr_record, wr_byte, wr_data} = ~{rec, idx, dat};
    endtask

    // caller picks any record: 00h, 01h, 80h..83h or an unmapped one
    task automatic rd(input logic [7:0] rec, input logic [4:0] idx, output logic [7:0] dat,
                      output logic vld, output logic err);
        @(posedge sys_clk);
        #1;
        {rd_record, rd_byte} = {rec, idx};
        rd_req = 1'b1;
        @(posedge sys_clk);
        #1;
        rd_req = 1'b0;
        dat = rd_data_q;
        vld = rd_valid_q;
        err = rd_err_q;
        {rd_record, rd_byte} = ~{rec, idx};
    endtask
endmodule // dpd_coupler

// file: di8_param_diag_registers_test.sv
// self-checking bench for the diag register set, record access through dpd_coupler
// assumes a 1 us tick shortened to 2 cycles so filter times stay short
`include "dpd_map.svh"
module di8_param_diag_registers_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TICK = 2;
    logic sys_clk, rst, module_fail_in, aux_supply_missing_in, comm_error_in, diag_overflow_in;
    logic [7:0] input_channel, wire_break_raw, rd_record, wr_record, wr_data, rd_data_q, filtered_inputs;
    logic [4:0] rd_byte, wr_byte;
    logic sys_stop, wr_req, rd_req, wr_ack_q, wr_err_q, rd_valid_q, rd_err_q, diag_irq_q;
    int failures = 0;
    int num_checks = 0;
    int irq_cnt = 0;
    int base;
    int ft[7] = '{`DPD_FT1_US, `DPD_FT2_US, `DPD_FT3_US, `DPD_FT4_US, `DPD_FT5_US, `DPD_FT6_US, `DPD_FT7_US};
    logic [7:0] pin_a[4] = '{8'h01, 8'h14, 8'h02, 8'h02};
    logic [7:0] pin_d[4] = '{8'h00, 8'h00, 8'h10, 8'h08};
    logic [7:0] consts[8] = '{8'h00, 8'h1f, 8'h00, 8'h00, 8'h70, 8'h08, 8'h08, 8'h00};
    logic [1:0] lvl;

    dpd_regs #(.NUM_CH(8), .US_TICK_CYC(TICK)) dut (.sys_clk, .rst, .input_channel, .wire_break_raw,
        .module_fail_in, .aux_supply_missing_in, .comm_error_in, .diag_overflow_in, .sys_stop, .wr_req,
        .wr_record, .wr_byte, .wr_data, .rd_req, .rd_record, .rd_byte, .wr_ack_q, .wr_err_q, .rd_valid_q,
        .rd_err_q, .rd_data_q, .filtered_inputs, .diag_irq_q);
    dpd_coupler u_cpl (.sys_clk, .wr_ack_q, .wr_err_q, .rd_valid_q, .rd_err_q, .rd_data_q, .sys_stop,
        .wr_req, .wr_record, .wr_byte, .wr_data, .rd_req, .rd_record, .rd_byte);

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        if (diag_irq_q === 1'b1) irq_cnt <= irq_cnt + 1;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wrc(input logic [7:0] rec, input logic [4:0] idx, input logic [7:0] dat, input logic stop,
                       input logic take);
        logic a, e;
        u_cpl.wr(rec, idx, dat, stop, a, e);
        chk($sformatf("write answer rec %h", rec), {6'h00, take, ~take}, {6'h00, a, e});
    endtask

    task automatic rdc(input logic [7:0] rec, input logic [4:0] idx, input logic [7:0] exp, input logic bad = 1'b0);
        logic [7:0] d;
        logic v, e;
        u_cpl.rd(rec, idx, d, v, e);
        chk($sformatf("read answer rec %h byte %h", rec, idx), {6'h00, 1'b1, bad}, {6'h00, v, e});
        chk($sformatf("read data rec %h byte %h", rec, idx), exp, d);
    endtask

    task automatic settle();
        repeat (8) @(posedge sys_clk);
    endtask

    task automatic summarize();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // tests take about 73k cycles; limit at 90k cycles
    initial begin
        #450us;
        failures++;
        summarize();
    end

    initial begin
        rst = 1'b1;
        {input_channel, wire_break_raw} = '0;
        {module_fail_in, aux_supply_missing_in, comm_error_in, diag_overflow_in} = 4'h0;
        repeat (8) @(posedge sys_clk);
        #1 rst = 1'b0;
        for (int i = 0; i < 4; i++) rdc(8'h80 + 8'(i), 5'h00, 8'h11);
        for (int i = 0; i < 8; i++) rdc(8'h01, 5'(i), consts[i]);
        for (int i = 16; i < 20; i++) rdc(8'h01, 5'(i), 8'h00);
        rdc(8'h00, 5'h01, 8'h1f);
        rdc(8'h00, 5'h04, 8'h00, 1'b1);
        rdc(8'h02, 5'h00, 8'h00, 1'b1);
        $display("test reset values done");
        wrc(8'h00, 5'h00, 8'h40, 1'b0, 1'b0);
        wrc(8'h00, 5'h00, 8'h40, 1'b1, 1'b1);
        wrc(8'h00, 5'h01, 8'h05, 1'b1, 1'b1);
        wrc(8'h84, 5'h00, 8'h22, 1'b1, 1'b0);
        wrc(8'h81, 5'h00, 8'h23, 1'b0, 1'b1);
        rdc(8'h81, 5'h00, 8'h23);
        $display("test record writes done");
        base = irq_cnt;
        wire_break_raw = 8'h03;
        settle();
        rdc(8'h01, 5'h08, 8'h10);
        rdc(8'h01, 5'h09, 8'h00);
        rdc(8'h01, 5'h07, 8'h01);
        rdc(8'h01, 5'h00, 8'h0c);
        chk("irq pulses", 8'h01, 8'(irq_cnt - base));
        wrc(8'h00, 5'h00, 8'h00, 1'b1, 1'b1);
        base = irq_cnt;
        wire_break_raw = 8'h07;
        settle();
        rdc(8'h01, 5'h07, 8'h05);
        chk("irq pulses", 8'h00, 8'(irq_cnt - base));
        wire_break_raw = 8'h00;
        $display("test wire break done");
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            #1 {module_fail_in, aux_supply_missing_in, comm_error_in, diag_overflow_in} = 4'h8 >> i;
            settle();
            rdc(8'h01, 5'h00, pin_a[i]);
            rdc(8'h01, 5'h03, pin_d[i]);
        end
        {module_fail_in, aux_supply_missing_in, comm_error_in, diag_overflow_in} = 4'h0;
        $display("test status pins done");
        // high nibble 8, low nibble F and high nibble 0 are all impermissible
        wrc(8'h82, 5'h00, 8'h81, 1'b0, 1'b1);
        wrc(8'h83, 5'h00, 8'h0f, 1'b0, 1'b1);
        settle();
        rdc(8'h01, 5'h0d, 8'h01);
        rdc(8'h01, 5'h07, 8'he0);
        rdc(8'h01, 5'h00, 8'h88);
        wrc(8'h82, 5'h00, 8'h11, 1'b0, 1'b1);
        wrc(8'h83, 5'h00, 8'h11, 1'b0, 1'b1);
        settle();
        rdc(8'h01, 5'h00, 8'h00);
        $display("test illegal codes done");
        wrc(8'h80, 5'h00, 8'h11, 1'b0, 1'b1);
        input_channel = 8'h01;
        repeat (40) @(posedge sys_clk);
        #1 input_channel = 8'h00;
        repeat (300) @(posedge sys_clk);
        chk("glitch filtered", 8'h00, filtered_inputs);
        // odd channel fixed at code 1, so it changes long before slower even codes
        lvl = 2'b00;
        for (int c = 1; c < 8; c++) begin
            wrc(8'h80, 5'h00, {4'h1, 4'(c)}, 1'b0, 1'b1);
            input_channel = {6'h00, ~lvl};
            repeat (ft[c-1] * TICK - 20) @(posedge sys_clk);
            chk($sformatf("filter early code %0d", c), {6'h00, (c == 1) ? lvl : {~lvl[1], lvl[0]}},
                filtered_inputs);
            repeat (40) @(posedge sys_clk);
            lvl = ~lvl;
            chk($sformatf("filter late code %0d", c), {6'h00, lvl}, filtered_inputs);
        end
        $display("test filter times done");
        summarize();
    end
endmodule // di8_param_diag_registers_test
